/* pkg/jtag_scan_pkg.sv */
// constants for the identification and boundary-scan data registers
// assumes a 100 MHz system clock that oversamples the test clock
package jtag_scan_pkg;
    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_HIGHZ = 3'h5;
    localparam logic [2:0] IR_CLAMP = 3'h6;
    localparam int IR_W = 3;
    // ------------------------------------------------------------
    // identification register layout
    // ------------------------------------------------------------
    localparam int ID_LEN = 32;
    localparam int ID_REV_LSB = 28;
    localparam int ID_CTR_LSB = 22;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam logic ID_MARK = 1'b1;
    // ------------------------------------------------------------
    // boundary chain cell positions
    // ------------------------------------------------------------
    localparam int CHAIN_LEN = 122;
    localparam int C_AHI = 0;
    localparam int C_ALO = 9;
    localparam int C_ALO_CTL = 57;
    localparam int C_PP = 58;
    localparam int C_I2C = 82;
    localparam int C_TIMER_OUT_PIN = 86;
    localparam int C_CLK = 88;
    localparam int C_TIN = 89;
    localparam int C_SER = 91;
    localparam int C_TRI = 99;
    localparam int C_DATA = 100;
    localparam int N_AHI = 3;
    localparam int N_ALO = 24;
    localparam int N_PP = 8;
    localparam int N_DATA = 11;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_IDCODE = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int ST_EXT_BIT = 3;
    localparam int ST_HZ_BIT = 4;
    localparam int ST_EN_BIT = 5;
endpackage : jtag_scan_pkg

/* verilog/pin_sync3.sv */
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to SYS_CLK
module pin_sync3 #(
    parameter int W = 1
) (
    input logic SYS_CLK, // system clock
    input logic RESET, // sync reset, active high
    input logic [W-1:0] PIN_IN, // raw pins
    output logic [W-1:0] PIN_SYNC // filtered level
);
    if (W < 1) begin : g_chk
        $error("pin_sync3 needs W >= 1");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = PIN_IN;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // take a bit only where the last two stages agree
        st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign PIN_SYNC = st_r.lvl;
endmodule : pin_sync3

/* verilog/jtag_id_bscan.sv */
// identification and boundary-scan data registers of the test port
// assumes an outside TAP machine giving level strobes on its own TCK;
// all test signals are oversampled by SYS_CLK
module jtag_id_bscan
    import jtag_scan_pkg::*;
#(
    parameter logic [3:0] ID_REV = 4'h0, // arbitrary value
    parameter logic [5:0] ID_CTR = 6'h2a, // arbitrary value
    parameter logic [9:0] ID_DEV = 10'h155, // arbitrary value
    parameter logic [10:0] ID_MFR = 11'h2aa, // arbitrary value
    parameter int APB_AW = 8
) (
    input logic SYS_CLK, // system clock
    input logic RESET, // sync reset
    input logic TCK, // test clock pin
    input logic TRST_N, // test reset pin
    input logic TDI, // serial test in
    output logic TDO, // serial test out
    output logic TDO_EN, // TDO driven by this block
    input logic TEST_LOGIC_RESET, // TAP in reset state
    input logic CAPTURE_DR, // TAP capture-DR
    input logic SHIFT_DR, // TAP shift-DR
    input logic UPDATE_DR, // TAP update-DR
    input logic UPDATE_IR, // TAP update-IR
    input logic [IR_W-1:0] IR_SHIFT, // instruction shift stages
    output logic [IR_W-1:0] INSTR, // active instruction
    output logic FUNC_RESET, // test mode holds core reset
    input logic [N_AHI-1:0] ADDR_HI_IN, // address 26..24 pins
    output logic [N_AHI-1:0] ADDR_HI_OUT, // pin drive
    output logic [N_AHI-1:0] ADDR_HI_OE, // pin enable
    input logic [N_AHI-1:0] CORE_ADDR_HI_OUT, // core value
    input logic [N_AHI-1:0] CORE_ADDR_HI_OE, // core enable
    input logic [N_ALO-1:0] ADDR_LO_IN, // address 23..0 pins
    output logic [N_ALO-1:0] ADDR_LO_OUT, // pin drive
    output logic ADDR_LO_OE, // group enable
    input logic [N_ALO-1:0] CORE_ADDR_LO_OUT, // core value
    input logic CORE_ADDR_LO_OE, // core enable
    input logic [N_PP-1:0] PARALLEL_PORT_PIN_IN, // port pins
    output logic [N_PP-1:0] PARALLEL_PORT_PIN_OUT, // pin drive
    output logic [N_PP-1:0] PARALLEL_PORT_PIN_OE, // pin enable
    input logic [N_PP-1:0] CORE_PP_OUT, // core value
    input logic [N_PP-1:0] CORE_PP_OE, // core enable
    input logic [1:0] I2C_IN, // bit0 clock, bit1 data
    output logic [1:0] I2C_OUT, // pin drive
    output logic [1:0] I2C_OE, // pin enable
    input logic [1:0] CORE_I2C_OUT, // core value
    input logic [1:0] CORE_I2C_OE, // core enable
    output logic [1:0] TIMER_OUT_PIN, // timer outputs
    input logic [1:0] CORE_TIMER_OUT, // core value
    input logic CLK_PIN_IN, // clock input pin
    input logic [1:0] TIMER_IN_PIN, // timer inputs
    output logic [1:0] SER_TX_OUT, // serial transmit
    output logic [1:0] SER_RTS_OUT, // request to send
    input logic [1:0] CORE_SER_TX, // core value
    input logic [1:0] CORE_SER_RTS, // core value
    input logic [1:0] SER_RX_IN, // serial receive
    input logic [1:0] SER_CTS_IN, // clear to send
    output logic FIXED_OUT_OE, // enable, output-only pins
    input logic TRISTATE_REQUEST_PIN, // tristate request
    input logic [N_DATA-1:0] DATA_BUS_PIN_IN, // data pins
    output logic [N_DATA-1:0] DATA_BUS_PIN_OUT, // pin drive
    output logic DATA_BUS_PIN_OE, // group enable
    input logic [N_DATA-1:0] CORE_DATA_OUT, // core value
    input logic CORE_DATA_OE, // core enable
    input logic DATA_TEST_OE, // enable cell, upper chain
    input logic PSEL, // APB select
    input logic PENABLE, // APB enable
    input logic PWRITE, // APB write
    input logic [APB_AW-1:0] PADDR, // APB address
    input logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR // APB error
);
    if (APB_AW < 8) begin : g_chk
        $error("jtag_id_bscan needs APB_AW >= 8");
    end

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    localparam int SYN_W = 11 + N_AHI + N_ALO + N_PP + 10 + N_DATA;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_REV, ID_CTR, ID_DEV,
        ID_MFR, ID_MARK};

    logic [SYN_W-1:0] syn;
    logic tck, trst_n, tdi, tlr, cap_dr, sh_dr, up_dr, up_ir, clk_in, tri_in;
    logic [IR_W-1:0] ir_sh;
    logic [N_AHI-1:0] ahi_in;
    logic [N_ALO-1:0] alo_in;
    logic [N_PP-1:0] pp_in;
    logic [1:0] i2c_in, tin_in, rx_in, cts_in;
    logic [N_DATA-1:0] d_in;

    pin_sync3 #(.W(SYN_W)) u_sync (
        .SYS_CLK(SYS_CLK),
        .RESET(RESET),
        .PIN_IN({DATA_BUS_PIN_IN, TRISTATE_REQUEST_PIN, SER_CTS_IN, SER_RX_IN, TIMER_IN_PIN, CLK_PIN_IN,
                 I2C_IN, PARALLEL_PORT_PIN_IN, ADDR_LO_IN, ADDR_HI_IN, IR_SHIFT, UPDATE_IR, UPDATE_DR,
                 SHIFT_DR, CAPTURE_DR, TEST_LOGIC_RESET, TDI, TRST_N, TCK}),
        .PIN_SYNC(syn)
    );

    assign {d_in, tri_in, cts_in, rx_in, tin_in, clk_in, i2c_in, pp_in, alo_in, ahi_in, ir_sh, up_ir,
            up_dr, sh_dr, cap_dr, tlr, tdi, trst_n, tck} = syn;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [IR_W-1:0] instr;
        logic tck_q;
        logic [ID_LEN-1:0] id_sh;
        logic [CHAIN_LEN-1:0] bsr;
        logic [CHAIN_LEN-1:0] upd;
        logic tdo;
        logic ctl_en;
        logic [N_AHI-1:0] ahi_o;
        logic [N_AHI-1:0] ahi_oe;
        logic [N_ALO-1:0] alo_o;
        logic alo_oe;
        logic [N_PP-1:0] pp_o;
        logic [N_PP-1:0] pp_oe;
        logic [1:0] i2c_o;
        logic [1:0] i2c_oe;
        logic [1:0] timer_out_pin_o;
        logic [1:0] tx_o;
        logic [1:0] rts_o;
        logic fix_oe;
        logic [N_DATA-1:0] d_o;
        logic d_oe;
        logic [31:0] prdata;
        logic perr;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic rise, fall, id_sel, bsr_sel, ext, hz;
    logic [CHAIN_LEN-1:0] cap;

    // TCK edges only seen while software leaves the port enabled
    assign rise = tck & ~s_r.tck_q & s_r.ctl_en;
    assign fall = ~tck & s_r.tck_q & s_r.ctl_en;
    assign id_sel = (s_r.instr == IR_IDCODE);
    assign bsr_sel = (s_r.instr == IR_EXTEST) || (s_r.instr == IR_SAMPLE);
    assign ext = (s_r.instr == IR_EXTEST) || (s_r.instr == IR_CLAMP);
    assign hz = (s_r.instr == IR_HIGHZ);

    // ------------------------------------------------------------
    // capture vector: pins on input cells, core values elsewhere
    // ------------------------------------------------------------
    always_comb begin
        cap = '0;
        for (int j = 0; j < N_AHI; j++) begin
            cap[C_AHI + 3 * j] = ahi_in[N_AHI - 1 - j];
            cap[C_AHI + 3 * j + 1] = CORE_ADDR_HI_OUT[N_AHI - 1 - j];
            cap[C_AHI + 3 * j + 2] = CORE_ADDR_HI_OE[N_AHI - 1 - j];
        end
        for (int j = 0; j < N_ALO; j++) begin
            cap[C_ALO + 2 * j] = alo_in[N_ALO - 1 - j];
            cap[C_ALO + 2 * j + 1] = CORE_ADDR_LO_OUT[N_ALO - 1 - j];
        end
        cap[C_ALO_CTL] = CORE_ADDR_LO_OE;
        for (int j = 0; j < N_PP; j++) begin
            cap[C_PP + 3 * j] = pp_in[j];
            cap[C_PP + 3 * j + 1] = CORE_PP_OUT[j];
            cap[C_PP + 3 * j + 2] = CORE_PP_OE[j];
        end
        for (int j = 0; j < 2; j++) begin
            cap[C_I2C + 2 * j] = i2c_in[j];
            cap[C_I2C + 2 * j + 1] = CORE_I2C_OUT[j];
            cap[C_TIMER_OUT_PIN + j] = CORE_TIMER_OUT[1 - j];
            cap[C_TIN + j] = tin_in[1 - j];
            cap[C_SER + 4 * j] = CORE_SER_TX[j];
            cap[C_SER + 4 * j + 1] = rx_in[j];
            cap[C_SER + 4 * j + 2] = CORE_SER_RTS[j];
            cap[C_SER + 4 * j + 3] = cts_in[j];
        end
        cap[C_CLK] = clk_in;
        cap[C_TRI] = tri_in;
        for (int j = 0; j < N_DATA; j++) begin
            cap[C_DATA + 2 * j] = d_in[j];
            cap[C_DATA + 2 * j + 1] = CORE_DATA_OUT[j];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.tck_q = tck;
        if (!trst_n || tlr) begin
            s_nxt.instr = IR_IDCODE;
        end else if (fall && up_ir) begin
            s_nxt.instr = ir_sh;
        end
        if (rise && cap_dr) begin
            if (id_sel) begin
                s_nxt.id_sh = ID_VALUE;
            end
            if (bsr_sel) begin
                s_nxt.bsr = cap;
            end
        end else if (rise && sh_dr) begin
            if (id_sel) begin
                s_nxt.id_sh = {tdi, s_r.id_sh[ID_LEN-1:1]};
            end
            if (bsr_sel) begin
                s_nxt.bsr = {tdi, s_r.bsr[CHAIN_LEN-1:1]};
            end
        end
        // update cells load on the falling edge, as in update-DR
        if (fall && up_dr && bsr_sel) begin
            s_nxt.upd = s_r.bsr;
        end
        if (fall) begin
            s_nxt.tdo = id_sel ? s_r.id_sh[0] : s_r.bsr[0];
        end
        // pin drive: core in normal mode, update cells under extest/clamp
        for (int j = 0; j < N_AHI; j++) begin
            s_nxt.ahi_o[N_AHI-1-j] = ext ? s_r.upd[C_AHI + 3 * j + 1] : CORE_ADDR_HI_OUT[N_AHI-1-j];
            s_nxt.ahi_oe[N_AHI-1-j] = ext ? s_r.upd[C_AHI + 3 * j + 2] : CORE_ADDR_HI_OE[N_AHI-1-j];
        end
        for (int j = 0; j < N_ALO; j++) begin
            s_nxt.alo_o[N_ALO-1-j] = ext ? s_r.upd[C_ALO + 2 * j + 1] : CORE_ADDR_LO_OUT[N_ALO-1-j];
        end
        s_nxt.alo_oe = ext ? s_r.upd[C_ALO_CTL] : CORE_ADDR_LO_OE;
        for (int j = 0; j < N_PP; j++) begin
            s_nxt.pp_o[j] = ext ? s_r.upd[C_PP + 3 * j + 1] : CORE_PP_OUT[j];
            s_nxt.pp_oe[j] = ext ? s_r.upd[C_PP + 3 * j + 2] : CORE_PP_OE[j];
        end
        for (int j = 0; j < 2; j++) begin
            // no enable cell: open drain, only a low is driven in test
            s_nxt.i2c_o[j] = ext ? s_r.upd[C_I2C + 2 * j + 1] : CORE_I2C_OUT[j];
            s_nxt.i2c_oe[j] = ext ? ~s_r.upd[C_I2C + 2 * j + 1] : CORE_I2C_OE[j];
            s_nxt.timer_out_pin_o[1-j] = ext ? s_r.upd[C_TIMER_OUT_PIN + j] : CORE_TIMER_OUT[1-j];
            s_nxt.tx_o[j] = ext ? s_r.upd[C_SER + 4 * j] : CORE_SER_TX[j];
            s_nxt.rts_o[j] = ext ? s_r.upd[C_SER + 4 * j + 2] : CORE_SER_RTS[j];
        end
        s_nxt.fix_oe = 1'b1;
        for (int j = 0; j < N_DATA; j++) begin
            s_nxt.d_o[j] = ext ? s_r.upd[C_DATA + 2 * j + 1] : CORE_DATA_OUT[j];
        end
        // data enable cell lies in the upper chain segment
        s_nxt.d_oe = ext ? DATA_TEST_OE : CORE_DATA_OE;
        if (hz) begin
            s_nxt.ahi_oe = '0;
            s_nxt.alo_oe = 1'b0;
            s_nxt.pp_oe = '0;
            s_nxt.i2c_oe = '0;
            s_nxt.fix_oe = 1'b0;
            s_nxt.d_oe = 1'b0;
        end
        // APB: read data prepared in setup so it stands in the access phase
        if (PSEL && !PENABLE) begin
            s_nxt.perr = 1'b0;
            s_nxt.prdata = '0;
            case (PADDR[7:0])
                REG_STATUS: begin
                    s_nxt.prdata[IR_W-1:0] = s_r.instr;
                    s_nxt.prdata[ST_EXT_BIT] = ext;
                    s_nxt.prdata[ST_HZ_BIT] = hz;
                    s_nxt.prdata[ST_EN_BIT] = s_r.ctl_en;
                end
                REG_CTRL: s_nxt.prdata[CTRL_EN_BIT] = s_r.ctl_en;
                REG_IDCODE: s_nxt.prdata = ID_VALUE;
                default: s_nxt.perr = 1'b1;
            endcase
        end
        if (PSEL && PENABLE && PWRITE && PADDR[7:0] == REG_CTRL && !s_r.perr) begin
            s_nxt.ctl_en = PWDATA[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            s_r <= '0;
            s_r.instr <= IR_IDCODE;
            s_r.ctl_en <= CTRL_EN_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign TDO = s_r.tdo;
    assign TDO_EN = sh_dr & (id_sel | bsr_sel) & s_r.ctl_en;
    assign INSTR = s_r.instr;
    assign FUNC_RESET = ext | hz;
    assign ADDR_HI_OUT = s_r.ahi_o;
    assign ADDR_HI_OE = s_r.ahi_oe;
    assign ADDR_LO_OUT = s_r.alo_o;
    assign ADDR_LO_OE = s_r.alo_oe;
    assign PARALLEL_PORT_PIN_OUT = s_r.pp_o;
    assign PARALLEL_PORT_PIN_OE = s_r.pp_oe;
    assign I2C_OUT = s_r.i2c_o;
    assign I2C_OE = s_r.i2c_oe;
    assign TIMER_OUT_PIN = s_r.timer_out_pin_o;
    assign SER_TX_OUT = s_r.tx_o;
    assign SER_RTS_OUT = s_r.rts_o;
    assign FIXED_OUT_OE = s_r.fix_oe;
    assign DATA_BUS_PIN_OUT = s_r.d_o;
    assign DATA_BUS_PIN_OE = s_r.d_oe;
    assign PRDATA = s_r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & s_r.perr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_id_load;
        @(posedge SYS_CLK) disable iff (RESET) (rise && cap_dr && id_sel) |=> (s_r.id_sh == ID_VALUE);
    endproperty
    a_id_load: assert property (p_id_load) else $error("id capture wrong");
    property p_id_rev;
        @(posedge SYS_CLK) disable iff (RESET) (rise && cap_dr && id_sel) |=> (s_r.id_sh[31:28] == ID_REV);
    endproperty
    a_id_rev: assert property (p_id_rev) else $error("revision field wrong");
    property p_id_fix;
        @(posedge SYS_CLK) disable iff (RESET)
            (rise && cap_dr && id_sel) |=> (s_r.id_sh[27:22] == ID_CTR) && (s_r.id_sh[21:12] == ID_DEV);
    endproperty
    a_id_fix: assert property (p_id_fix) else $error("center or device field wrong");
    property p_id_low;
        @(posedge SYS_CLK) disable iff (RESET)
            (rise && cap_dr && id_sel) |=> (s_r.id_sh[11:1] == ID_MFR) ##1 (s_r.id_sh[0] == 1'b1);
    endproperty
    a_id_low: assert property (p_id_low) else $error("maker field or marker wrong");
    property p_bsr_shift;
        @(posedge SYS_CLK) disable iff (RESET) (rise && sh_dr && !cap_dr && bsr_sel)
            |=> (s_r.bsr[CHAIN_LEN-1] == $past(tdi)) && (s_r.bsr[CHAIN_LEN-2:0] == $past(s_r.bsr[CHAIN_LEN-1:1]));
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) else $error("chain shift wrong");
    property p_cap_map;
        @(posedge SYS_CLK) disable iff (RESET) (rise && cap_dr && bsr_sel)
            |=> (s_r.bsr[C_TRI] == $past(tri_in)) && (s_r.bsr[C_CLK] == $past(clk_in))
                && (s_r.bsr[C_DATA + 21] == $past(CORE_DATA_OUT[10])) && (s_r.bsr[C_PP + 2] == $past(CORE_PP_OE[0]));
    endproperty
    a_cap_map: assert property (p_cap_map) else $error("capture cell order wrong");
    property p_drive;
        @(posedge SYS_CLK) disable iff (RESET) (ext && !hz) ##1 ext
            |-> (s_r.alo_o[N_ALO-1] == $past(s_r.upd[C_ALO + 1])) && (s_r.pp_oe[0] == $past(s_r.upd[C_PP + 2]));
    endproperty
    a_drive: assert property (p_drive) else $error("test drive wrong");
    property p_highz;
        @(posedge SYS_CLK) disable iff (RESET) hz [*2] |-> !s_r.fix_oe && (s_r.pp_oe == '0) && !s_r.d_oe;
    endproperty
    a_highz: assert property (p_highz) else $error("enable left on in highz");
    property p_ir_reset;
        @(posedge SYS_CLK) disable iff (RESET) (!trst_n || tlr) |=> (s_r.instr == IR_IDCODE) && !FUNC_RESET;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("reset did not load idcode");
endmodule : jtag_id_bscan

/* tb/jtag_ctl_model.sv */
// board test controller model driving the test port
// assumes strobes act as tap state levels, moved well after each tck rise
module jtag_ctl_model (
    output logic tck, // test clock
    output logic trst_n, // test reset
    output logic tdi, // serial in
    input logic tdo, // serial out
    output logic tlr, // tap reset state
    output logic cap, // capture-dr
    output logic shf, // shift-dr
    output logic upd, // update-dr
    output logic updir, // update-ir
    output logic [2:0] ir // instruction stages
);
    timeunit 1ns;
    timeprecision 1ps;
    logic smp;
    initial begin
        {tck, tlr, cap, shf, upd, updir, tdi, ir} = '0;
        trst_n = 1'b1;
    end
    // tck stands low between frames; state moves late in the high half
    task automatic clk(input logic [3:0] nxt);
        #80 smp = tdo;
        tck <= 1'b1;
        #60 {cap, shf, upd, updir} <= nxt;
        #20 tck <= 1'b0;
    endtask : clk
    task automatic ir_load(input logic [2:0] code);
        ir <= code;
        clk(4'h1);
        clk(4'h0);
    endtask : ir_load
    task automatic dr_scan(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        clk(4'h8);
        clk(4'h4);
        for (int i = 0; i < n; i++) begin
            tdi <= din[i];
            clk((i == n - 1) ? 4'h2 : 4'h4);
            dout[i] = smp;
        end
        tdi <= ~tdi;
        clk(4'h0);
    endtask : dr_scan
    task automatic tap_reset(input logic by_pin);
        trst_n <= !by_pin;
        tlr <= !by_pin;
        clk(4'h0);
        {trst_n, tlr} <= 2'b10;
    endtask : tap_reset
endmodule : jtag_ctl_model

/* tb/jtag_id_and_boundary_scan_test.sv */
// self-checking bench for the id and boundary-scan registers
// assumes the controller model in jtag_ctl_model and apb at zero waits
module jtag_id_and_boundary_scan_test import jtag_scan_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDW = {4'h3, 6'h15, 10'h2d3, 11'h4b6, 1'b1}; // arbitrary id fields
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] seed = 32'h50;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [55:0] pin;
    logic [69:0] core;
    logic psel, pen, pwr, pready, perr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tck, trst_n, tdi, tdo, tdo_en, tlr, cap, shf, upd, updir, fres, ale, fxe, dbe;
    logic [2:0] irs, instr, aho, ahe;
    logic [23:0] alo;
    logic [7:0] ppo, ppe;
    logic [1:0] i2o, i2e, tmo, txo, rtso;
    logic [10:0] dbo;
    logic [127:0] din, dout, e, m;
    logic [69:0] outs;
    jtag_id_bscan #(.ID_REV(IDW[31:28]), .ID_CTR(IDW[27:22]), .ID_DEV(IDW[21:12]), .ID_MFR(IDW[11:1]))
        u_jtag_id_bscan (
        .SYS_CLK(clk), .RESET(rst), .TCK(tck), .TRST_N(trst_n), .TDI(tdi), .TDO(tdo), .TDO_EN(tdo_en),
        .TEST_LOGIC_RESET(tlr), .CAPTURE_DR(cap), .SHIFT_DR(shf), .UPDATE_DR(upd), .UPDATE_IR(updir),
        .IR_SHIFT(irs), .INSTR(instr), .FUNC_RESET(fres), .ADDR_HI_IN(pin[2:0]), .ADDR_HI_OUT(aho),
        .ADDR_HI_OE(ahe), .CORE_ADDR_HI_OUT(core[2:0]), .CORE_ADDR_HI_OE(core[5:3]), .ADDR_LO_IN(pin[26:3]),
        .ADDR_LO_OUT(alo), .ADDR_LO_OE(ale), .CORE_ADDR_LO_OUT(core[29:6]), .CORE_ADDR_LO_OE(core[30]),
        .PARALLEL_PORT_PIN_IN(pin[34:27]), .PARALLEL_PORT_PIN_OUT(ppo), .PARALLEL_PORT_PIN_OE(ppe),
        .CORE_PP_OUT(core[38:31]), .CORE_PP_OE(core[46:39]), .I2C_IN(pin[36:35]), .I2C_OUT(i2o), .I2C_OE(i2e),
        .CORE_I2C_OUT(core[48:47]), .CORE_I2C_OE(core[50:49]), .TIMER_OUT_PIN(tmo), .CORE_TIMER_OUT(core[52:51]),
        .CLK_PIN_IN(pin[37]), .TIMER_IN_PIN(pin[39:38]), .SER_TX_OUT(txo), .SER_RTS_OUT(rtso),
        .CORE_SER_TX(core[54:53]), .CORE_SER_RTS(core[56:55]), .SER_RX_IN(pin[41:40]), .SER_CTS_IN(pin[43:42]),
        .FIXED_OUT_OE(fxe), .TRISTATE_REQUEST_PIN(pin[44]), .DATA_BUS_PIN_IN(pin[55:45]), .DATA_BUS_PIN_OUT(dbo),
        .DATA_BUS_PIN_OE(dbe), .CORE_DATA_OUT(core[67:57]), .CORE_DATA_OE(core[68]), .DATA_TEST_OE(core[69]),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(perr)
    );
    // tdo line pulled up while the port does not drive it
    jtag_ctl_model u_jtag_ctl_model (.tck(tck), .trst_n(trst_n), .tdi(tdi), .tdo(tdo_en ? tdo : 1'b1), .tlr(tlr),
        .cap(cap), .shf(shf), .upd(upd), .updir(updir), .ir(irs));
    assign outs = {i2e, i2o, fres, dbe, dbo, rtso, txo, tmo, ppe, ppo, ale, alo, ahe, aho};
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [127:0] ex, input logic [127:0] got);
        check_count++;
        if (got !== ex) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, ex, got);
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    // input cells only; output and enable cells are masked off
    function automatic void cap_exp();
        {e, m} = '0;
        for (int k = 0; k < 3; k++) {e[3*k], m[3*k]} = {pin[2-k], 1'b1};
        for (int k = 0; k < 24; k++) {e[9+2*k], m[9+2*k]} = {pin[26-k], 1'b1};
        for (int k = 0; k < 8; k++) {e[58+3*k], m[58+3*k]} = {pin[27+k], 1'b1};
        for (int k = 0; k < 11; k++) {e[100+2*k], m[100+2*k]} = {pin[45+k], 1'b1};
        e[90:82] = {pin[38], pin[39], pin[37], 3'h0, pin[36], 1'b0, pin[35]};
        e[99:92] = {pin[44], pin[43], 1'b0, pin[41], 1'b0, pin[42], 1'b0, pin[40]};
        m[99:82] = 18'h355c5;
    endfunction : cap_exp
    function automatic logic [127:0] drv_exp();
        logic [127:0] x = '0;
        for (int k = 0; k < 3; k++) {x[2-k], x[5-k]} = {din[3*k+1], din[3*k+2]};
        for (int k = 0; k < 24; k++) x[29-k] = din[10+2*k];
        for (int k = 0; k < 8; k++) {x[31+k], x[39+k]} = {din[59+3*k], din[60+3*k]};
        for (int k = 0; k < 11; k++) x[53+k] = din[101+2*k];
        x[52:47] = {din[97], din[93], din[95], din[91], din[86], din[87]};
        x[65:64] = {1'b1, core[69]};
        x[30] = din[57];
        x[69:66] = {~din[85], ~din[83], din[85], din[83]};
        return x;
    endfunction : drv_exp
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        {psel, pen, pwr, paddr, pwdata, pin, core} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(REG_IDCODE, 1'b0, 32'h0);
        chk("id word", IDW, rd);
        apb(8'h0c, 1'b0, 32'h0);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rd);
        // port disabled: test clock edges must be ignored
        apb(REG_CTRL, 1'b1, 32'h0);
        u_jtag_ctl_model.ir_load(IR_SAMPLE);
        apb(REG_STATUS, 1'b0, 32'h0);
        chk("status disabled", 32'h1, rd);
        apb(REG_CTRL, 1'b1, 32'h1);
        u_jtag_ctl_model.ir_load(IR_SAMPLE);
        chk("instr loaded", IR_SAMPLE, instr);
        u_jtag_ctl_model.tap_reset(1'b1);
        chk("instr after trst", IR_IDCODE, instr);
        u_jtag_ctl_model.dr_scan(ID_LEN, '0, dout);
        chk("id scan", IDW, dout);
        $display("id test done");
        for (int t = 0; t < 2; t++) begin
            pin <= 56'({rnd(), rnd()});
            core <= 70'({rnd(), rnd(), rnd()});
            din = {rnd(), rnd(), rnd(), rnd()};
            u_jtag_ctl_model.ir_load(IR_SAMPLE);
            u_jtag_ctl_model.dr_scan(CHAIN_LEN, din, dout);
            cap_exp();
            chk("sample chain", e, dout & m);
            u_jtag_ctl_model.ir_load(IR_EXTEST);
            u_jtag_ctl_model.dr_scan(CHAIN_LEN, din, dout);
            chk("extest pins", drv_exp(), outs);
            $display("chain test %0d done", t);
        end
        u_jtag_ctl_model.ir_load(IR_CLAMP);
        chk("clamp pins", drv_exp(), outs);
        u_jtag_ctl_model.ir_load(IR_HIGHZ);
        chk("highz enables", 17'h10000, {fres, ahe, ale, ppe, i2e, fxe, dbe});
        u_jtag_ctl_model.tap_reset(1'b0);
        chk("instr after tap reset", IR_IDCODE, instr);
        $display("reset test done");
        finish_test();
    end
endmodule : jtag_id_and_boundary_scan_test
